// ==== core/port_ab_pin_function_mux.sv ====
// pin-function mux for port a/b pins shared with spi, pwm, fault and timer
`timescale 1ns/1ps
`default_nettype none
module port_ab_pin_function_mux
(
  // clock and reset
  input  wire logic                                    sys_clk,
  input  wire logic                                    rst,
  // system integration unit selects
  input  wire pin_mux_pkg::pin_fn_e [6:0]              fn_sel,
  input  wire logic [1:0]                              fault_pwm_mask,
  // gpio control and sampled input
  input  wire logic [6:0]                              gpio_dir_out,
  input  wire logic [6:0]                              gpio_data_out,
  output logic [6:0]                                   gpio_data_in,
  // spi
  input  wire pin_mux_pkg::spi_side_s                  spi,
  output logic                                         spi_miso_in,
  output logic                                         spi_mosi_in,
  // pwm and faults
  input  wire logic [4:0]                              pwm_out,
  output logic [1:0]                                   fault_in,
  // timers (index 0: channel 2, 1: channel 3)
  input  wire logic [1:0]                              timer_out,
  input  wire logic [1:0]                              timer_oe,
  output logic [1:0]                                   timer_in,
  // pins
  input  wire logic [6:0]                              pin_i,
  output logic [6:0]                                   pin_o,
  output logic [6:0]                                   pin_oe
);

  logic [6:0] meta_q;
  logic [6:0] sync_q;
  logic [6:0] pin_o_d;
  logic [6:0] pin_oe_d;
  logic [6:0] pin_o_q;
  logic [6:0] pin_oe_q;
  logic [1:0] fault_d;
  logic [1:0] timer_in_d;
  logic [1:0] fault_q;
  logic [1:0] timer_in_q;
  logic       miso_in_q;
  logic       mosi_in_q;
  logic       miso_in_d;
  logic       mosi_in_d;
  logic [4:0] pwm_gated;

  // pwm channels on pins a0,a1,a2,a4,a5; any masked fault disables all of them
  always_comb
  begin
    pwm_gated = pwm_out;
    if (|(fault_q & fault_pwm_mask))
    begin
      pwm_gated = 5'h00; // [R8]
    end
  end

  always_comb
  begin
    pin_o_d    = gpio_data_out;
    pin_oe_d   = gpio_dir_out; // [R2]
    fault_d    = 2'h0;
    timer_in_d = 2'h0;
    miso_in_d  = 1'h0;
    mosi_in_d  = 1'h0;
    // b2: gpio / miso / timer 2
    case (fn_sel[pin_mux_pkg::PIN_B2]) // [R3] [R11]
      pin_mux_pkg::FN_ALT1:
      begin
        pin_o_d[0]  = spi.miso_out; // [R6]
        pin_oe_d[0] = !spi.master && spi.ss_active; // [R4] [R5]
        miso_in_d   = sync_q[0];
      end
      pin_mux_pkg::FN_ALT2:
      begin
        pin_o_d[0]    = timer_out[0]; // [R9]
        pin_oe_d[0]   = timer_oe[0];
        timer_in_d[0] = sync_q[0];
      end
      default:
      begin
      end
    endcase
    // b3: gpio / mosi / timer 3
    case (fn_sel[pin_mux_pkg::PIN_B3])
      pin_mux_pkg::FN_ALT1:
      begin
        pin_o_d[1]  = spi.mosi_out; // [R7]
        pin_oe_d[1] = spi.master;
        mosi_in_d   = sync_q[1];
      end
      pin_mux_pkg::FN_ALT2:
      begin
        pin_o_d[1]    = timer_out[1]; // [R9]
        pin_oe_d[1]   = timer_oe[1];
        timer_in_d[1] = sync_q[1];
      end
      default:
      begin
      end
    endcase
    // a0, a1, a2: gpio / pwm
    for (int i = 0; i < 3; i++)
    begin
      if (fn_sel[pin_mux_pkg::PIN_A0 + i] == pin_mux_pkg::FN_ALT1)
      begin
        pin_o_d[2 + i]  = pwm_gated[i]; // [R10]
        pin_oe_d[2 + i] = 1'h1;
      end
    end
    // a4, a5: gpio / pwm / fault / timer
    for (int j = 0; j < 2; j++)
    begin
      case (fn_sel[pin_mux_pkg::PIN_A4 + j])
        pin_mux_pkg::FN_ALT1:
        begin
          pin_o_d[5 + j]  = pwm_gated[3 + j]; // [R10]
          pin_oe_d[5 + j] = 1'h1;
        end
        pin_mux_pkg::FN_ALT2:
        begin
          pin_oe_d[5 + j] = 1'h0;
          fault_d[j]      = sync_q[5 + j]; // [R8]
        end
        pin_mux_pkg::FN_ALT3:
        begin
          pin_o_d[5 + j]  = timer_out[j]; // [R9]
          pin_oe_d[5 + j] = timer_oe[j];
          timer_in_d[j]   = timer_in_d[j] | sync_q[5 + j];
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_q     <= 7'h00;
      sync_q     <= 7'h00;
      pin_o_q    <= 7'h00;
      pin_oe_q   <= 7'h00; // [R1]
      fault_q    <= 2'h0;
      timer_in_q <= 2'h0;
      miso_in_q  <= 1'h0;
      mosi_in_q  <= 1'h0;
    end
    else
    begin
      meta_q     <= pin_i;
      sync_q     <= meta_q;
      pin_o_q    <= pin_o_d;
      pin_oe_q   <= pin_oe_d;
      fault_q    <= fault_d;
      timer_in_q <= timer_in_d;
      miso_in_q  <= miso_in_d;
      mosi_in_q  <= mosi_in_d;
    end
  end

  assign pin_o        = pin_o_q;
  assign pin_oe       = pin_oe_q;
  assign gpio_data_in = sync_q;
  assign fault_in     = fault_q;
  assign timer_in     = timer_in_q;
  assign spi_miso_in  = miso_in_q;
  assign spi_mosi_in  = mosi_in_q;

  a_reset_gpio: assert property (@(posedge sys_clk) rst |=> pin_oe == 7'h00) // [R1]
    else $error("pins driven after reset");
  a_gpio_dir_follow: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
    (fn_sel[2] == pin_mux_pkg::FN_GPIO) |=> pin_oe[2] == $past(gpio_dir_out[2]))
    else $error("gpio direction not followed");
  a_gpio_data_follow: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
    (fn_sel[3] == pin_mux_pkg::FN_GPIO) |=> pin_o[3] == $past(gpio_data_out[3]))
    else $error("gpio data not followed");
  a_miso_master_in: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
    (fn_sel[0] == pin_mux_pkg::FN_ALT1 && spi.master) |=> !pin_oe[0])
    else $error("miso driven in master mode");
  a_miso_slave_out: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
    (fn_sel[0] == pin_mux_pkg::FN_ALT1 && !spi.master && spi.ss_active) |=> pin_oe[0])
    else $error("miso not driven in selected slave mode");
  a_miso_unselected: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
    (fn_sel[0] == pin_mux_pkg::FN_ALT1 && !spi.ss_active) |=> !pin_oe[0])
    else $error("miso driven while unselected");
  a_mosi_master_out: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    (fn_sel[1] == pin_mux_pkg::FN_ALT1) |=> pin_oe[1] == $past(spi.master) && pin_o[1] == $past(spi.mosi_out))
    else $error("mosi not driven by master");
  a_miso_slave_data: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
    (fn_sel[0] == pin_mux_pkg::FN_ALT1) |=> pin_o[0] == $past(spi.miso_out))
    else $error("miso data not passed");

  // fault path: synced pin sample becomes the registered fault flag
  sequence s_ext_fault_in_1_routed;
    fn_sel[5] == pin_mux_pkg::FN_ALT2;
  endsequence
  sequence s_ext_fault_in_1_taken;
    fault_in[0] == $past(sync_q[5]);
  endsequence
  a_fault_capture: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    s_ext_fault_in_1_routed |=> s_ext_fault_in_1_taken)
    else $error("fault input not captured");
  a_fault_disables: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    (|(fault_q & fault_pwm_mask) && fn_sel[2] == pin_mux_pkg::FN_ALT1) |=> !pin_o[2])
    else $error("pwm not disabled by fault");
  a_timer_a4_route: assert property (@(posedge sys_clk) disable iff (rst) // [R9]
    (fn_sel[5] == pin_mux_pkg::FN_ALT3) |=> pin_o[5] == $past(timer_out[0]))
    else $error("timer 2 not routed to a4");
  a_timer_b3_route: assert property (@(posedge sys_clk) disable iff (rst) // [R9]
    (fn_sel[1] == pin_mux_pkg::FN_ALT2 && fn_sel[6] != pin_mux_pkg::FN_ALT3) |=> timer_in[1] == $past(sync_q[1]))
    else $error("timer 3 input not routed from b3");
  a_pwm_drives: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    (fn_sel[3] == pin_mux_pkg::FN_ALT1) |=> pin_oe[3])
    else $error("pwm pin not output");
  a_periph_override: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
    (fn_sel[6] == pin_mux_pkg::FN_ALT2) |=> !pin_oe[6])
    else $error("fault pin driven");

endmodule
`default_nettype wire

// ==== core/pin_mux_pkg.sv ====
// package for the port a/b pin-function mux
// Notes on behaviour
// R1 - After reset every pin of the group is in general-purpose I/O use.
// R2 - In general-purpose use each pin's direction is set by software on its own.
// R3 - The alternate function of each pin is chosen by system integration unit settings.
// R4 - With SPI routed, the master-in/slave-out line is an input in master mode and an output in slave mode.
// R5 - An SPI slave that is not selected leaves its master-in/slave-out line undriven.
// R6 - A slave presents each MISO bit half a serial clock before the master samples it.
// R7 - A master presents each MOSI bit half a serial clock before the slave samples it.
// R8 - Fault pins routed as fault inputs let off-chip faults disable chosen PWM outputs; here any fault enabled in fault_pwm_mask disables all five.
// R9 - Timer channels two and three can each go to a port A pin or a port B pin.
// R10 - PWM channels sharing a port A pin drive that pin as outputs when selected.
// R11 - A pin given to a peripheral ignores its GPIO direction and data and follows the peripheral.
`default_nettype none
package pin_mux_pkg;

  localparam int NUM_PINS = 7;
  // pin index order
  localparam int PIN_B2 = 0;
  localparam int PIN_B3 = 1;
  localparam int PIN_A0 = 2;
  localparam int PIN_A1 = 3;
  localparam int PIN_A2 = 4;
  localparam int PIN_A4 = 5;
  localparam int PIN_A5 = 6;

  // function select code per pin
  typedef enum logic [1:0] {
    FN_GPIO,
    FN_ALT1,
    FN_ALT2,
    FN_ALT3
  } pin_fn_e;

  localparam pin_fn_e FN_RESET = FN_GPIO;

  // one pin's drive pair
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_s;

  // spi data-line side
  typedef struct packed {
    logic master;
    logic ss_active;
    logic mosi_out;
    logic miso_out;
  } spi_side_s;

endpackage
`default_nettype wire

// ==== test/periph_model.sv ====
// spi-side partner model: shifts a byte onto mosi or miso
`timescale 1ns/1ps
`default_nettype none
module periph_model
(
  // clock
  input  wire logic              sys_clk,
  // mode and data
  input  wire logic              master,
  input  wire logic              ss_active,
  input  wire logic              load,
  input  wire logic [7:0]        tx_byte,
  // to the mux
  output var pin_mux_pkg::spi_side_s spi
);
  // known start so the mux never passes an unknown level
  logic [7:0] sr_q = 8'h00;
  // bits move on the falling edge, half a clock before sampling
  always @(negedge sys_clk)
    sr_q <= load ? tx_byte : {sr_q[6:0], ~sr_q[7]};
  // unselected slave output is the inverse of sr_q[7] so a stale level cannot pass
  always_comb
    spi = '{master, ss_active, sr_q[7], ss_active ? sr_q[7] : ~sr_q[7]};
endmodule
`default_nettype wire

// ==== test/port_ab_pin_function_mux_tb.sv ====
// self-checking bench for the port a/b pin-function mux
`timescale 1ns/1ps
`default_nettype none
module port_ab_pin_function_mux_tb;
  logic                       sys_clk = 1'b0;
  logic                       rst = 1'b1;
  pin_mux_pkg::pin_fn_e [6:0] fn_sel;
  logic [1:0]                 fault_pwm_mask = 2'h0;
  logic [6:0]                 gpio_dir_out = 7'h00;
  logic [6:0]                 gpio_data_out = 7'h00;
  logic [6:0]                 gpio_data_in;
  pin_mux_pkg::spi_side_s     spi;
  logic                       spi_miso_in;
  logic                       spi_mosi_in;
  logic [4:0]                 pwm_out = 5'h00;
  logic [1:0]                 fault_in;
  logic [1:0]                 timer_out = 2'h0;
  logic [1:0]                 timer_oe = 2'h0;
  logic [1:0]                 timer_in;
  logic [6:0]                 pin_i = 7'h5a;
  logic [6:0]                 pin_o;
  logic [6:0]                 pin_oe;
  logic                       master = 1'b1;
  logic                       ss_active = 1'b0;
  logic                       load = 1'b0;
  int                         n_errors = 0;
  int                         checked = 0;
  localparam logic [7:0]      tx_pattern = 8'ha5;
  always #2.5 sys_clk = ~sys_clk;
  port_ab_pin_function_mux port_ab_pin_function_mux_i (.sys_clk(sys_clk), .rst(rst), .fn_sel(fn_sel),
    .fault_pwm_mask(fault_pwm_mask), .gpio_dir_out(gpio_dir_out), .gpio_data_out(gpio_data_out),
    .gpio_data_in(gpio_data_in), .spi(spi), .spi_miso_in(spi_miso_in), .spi_mosi_in(spi_mosi_in),
    .pwm_out(pwm_out), .fault_in(fault_in), .timer_out(timer_out), .timer_oe(timer_oe),
    .timer_in(timer_in), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
  periph_model periph_model_i (.sys_clk(sys_clk), .master(master), .ss_active(ss_active),
    .load(load), .tx_byte(tx_pattern), .spi(spi));
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string what, input logic [6:0] seen, input logic [6:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // serial byte on pin b, one bit per cycle
  task automatic stream(input int b);
    load <= 1'b1;
    step(1);
    load <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      step(1);
      chk("serial", {6'h0, pin_o[b]}, {6'h0, tx_pattern[i]});
    end
  endtask
  task automatic t_gpio();
    chk("rst oe", pin_oe, 7'h00);
    chk("rst din", gpio_data_in, 7'h5a);
    gpio_dir_out = 7'h55;
    gpio_data_out = 7'h33;
    step(2);
    chk("oe", pin_oe, 7'h55);
    chk("out", pin_o & pin_oe, 7'h11);
    gpio_dir_out = 7'h2a;
    step(2);
    chk("oe", pin_oe, 7'h2a);
    chk("out", pin_o & pin_oe, 7'h22);
    $display("gpio done");
  endtask
  task automatic t_pwm();
    gpio_dir_out = 7'h7f;
    gpio_data_out = 7'h03;
    for (int p = 2; p < 7; p++)
      fn_sel[p] = pin_mux_pkg::FN_ALT1;
    pwm_out = 5'h0a;
    step(2);
    chk("pwm oe", pin_oe, 7'h7f);
    chk("pwm out", pin_o, 7'h2b);
    fn_sel[5] = pin_mux_pkg::FN_ALT2;
    fn_sel[6] = pin_mux_pkg::FN_ALT2;
    fault_pwm_mask = 2'h2;
    pwm_out = 5'h07;
    pin_i = 7'h20;
    step(6);
    chk("fault", {5'h0, fault_in}, 7'h01);
    chk("unmasked", pin_o & 7'h1c, 7'h1c);
    chk("fault oe", pin_oe, 7'h1f);
    pin_i = 7'h40;
    step(6);
    chk("kill", pin_o & 7'h1c, 7'h00);
    pin_i = 7'h00;
    step(6);
    chk("revive", pin_o & 7'h1c, 7'h1c);
    $display("pwm done");
  endtask
  task automatic t_timer();
    fn_sel = '{default: pin_mux_pkg::FN_GPIO};
    gpio_dir_out = 7'h00;
    fn_sel[0] = pin_mux_pkg::FN_ALT2;
    fn_sel[6] = pin_mux_pkg::FN_ALT3;
    gpio_data_out = 7'h00;
    timer_oe = 2'h1;
    timer_out = 2'h3;
    pin_i = 7'h40;
    step(4);
    chk("tmr oe", pin_oe, 7'h01);
    chk("tmr out", pin_o & 7'h41, 7'h41);
    chk("tmr in", {5'h0, timer_in}, 7'h02);
    fn_sel[0] = pin_mux_pkg::FN_GPIO;
    fn_sel[6] = pin_mux_pkg::FN_GPIO;
    fn_sel[5] = pin_mux_pkg::FN_ALT3;
    fn_sel[1] = pin_mux_pkg::FN_ALT2;
    timer_oe = 2'h2;
    timer_out = 2'h3;
    pin_i = 7'h20;
    step(4);
    chk("tmr oe", pin_oe, 7'h02);
    chk("tmr out", pin_o & 7'h22, 7'h22);
    chk("tmr in", {5'h0, timer_in}, 7'h01);
    $display("timer done");
  endtask
  task automatic t_spi();
    fn_sel = '{default: pin_mux_pkg::FN_GPIO};
    fn_sel[0] = pin_mux_pkg::FN_ALT1;
    fn_sel[1] = pin_mux_pkg::FN_ALT1;
    timer_oe = 2'h0;
    gpio_dir_out = 7'h03;
    pin_i = 7'h01;
    step(4);
    chk("mst oe", pin_oe, 7'h02);
    chk("miso in", {6'h0, spi_miso_in}, 7'h01);
    stream(1);
    master = 1'b0;
    step(2);
    chk("unsel oe", pin_oe, 7'h00);
    ss_active = 1'b1;
    pin_i = 7'h02;
    step(4);
    chk("slv oe", pin_oe, 7'h01);
    chk("mosi in", {6'h0, spi_mosi_in}, 7'h01);
    stream(0);
    $display("spi done");
  endtask
  // reset in mid-run with pins driven, then the first edges after release
  task automatic t_reset();
    fn_sel = '{default: pin_mux_pkg::FN_RESET};
    gpio_dir_out = 7'h7f;
    pin_i = 7'h33;
    step(3);
    chk("pre oe", pin_oe, 7'h7f);
    rst = 1'h1;
    step(2);
    chk("mid rst oe", pin_oe, 7'h00);
    chk("mid rst din", gpio_data_in, 7'h00);
    rst = 1'h0;
    step(1);
    chk("rel oe", pin_oe, 7'h7f);
    chk("rel din", gpio_data_in, 7'h00);
    step(1);
    chk("rel din", gpio_data_in, 7'h33);
    $display("reset done");
  endtask
  initial
  begin
    fn_sel = '{default: pin_mux_pkg::FN_GPIO};
    step(4);
    rst = 1'b0;
    step(3);
    t_gpio();
    t_pwm();
    t_timer();
    t_spi();
    t_reset();
    wrap_up();
  end
  initial
  begin
    step(400);
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
